// [sim/iop89_board.sv]
`timescale 1ns/1ps
`default_nettype none
module iop89_board (
  input wire logic [7:0] p8_out,
  input wire logic [7:0] p8_oe,
  input wire logic [4:0] p9_out,
  input wire logic [4:0] p9_oe,
  input wire logic [7:0] b8,
  input wire logic [4:0] b9,
  output logic [7:0] p8_in,
  output logic [4:0] p9_in
);
  // Board levels are set apart from the chip's data so reads show their source
  assign p8_in = (p8_oe & p8_out) | (~p8_oe & b8);
  assign p9_in = (p9_oe & p9_out) | (~p9_oe & b9);
endmodule
`default_nettype wire

// [sim/iop89_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module iop89_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic [7:0] p8_in,
  input wire logic [7:0] p8_oe,
  input wire logic [4:0] p9_out,
  input wire logic [4:0] p9_oe,
  input wire logic capture_in_d
);
  logic [16:0] a_r;
  logic [2:0] md_r;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      a_r <= 17'h0;
    else
      a_r <= (hsel && htrans[1]) ? {hwrite, haddr[15:0]} : 17'h0;
  // Mode copy, so pin holds can be judged
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      md_r <= 3'h0;
    else if (a_r == 17'h1fff0 && hwdata[2:0] < 3'h6)
      md_r <= hwdata[2:0];
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  AST_CAP_D: assert property ($past(hresetn) |-> capture_in_d == $past(p8_in[6]))
    else $error("capture d late");
  AST_P8_DIR: assert property (a_r == 17'h0ffe8 |-> hrdata[7:0] == 8'hff)
    else $error("p8 dir read");
  AST_P9_DIR: assert property (a_r == 17'h0ffec |-> hrdata[7:0] == 8'hff)
    else $error("p9 dir read");
  AST_P9_FIX: assert property (a_r == 17'h0ffdc |-> hrdata[7:5] == 3'h6)
    else $error("p9 fixed bits");
  AST_RST: assert property ($rose(hresetn) |-> p8_oe == 8'h00 && p9_oe == 5'h00)
    else $error("driving in reset");
  AST_STBY: assert property (md_r == 3'h5 |=> p8_oe == 8'h00 && p9_oe == 5'h00)
    else $error("driving in standby");
  AST_HOLD9: assert property (md_r inside {3'h2, 3'h3, 3'h4} |=> $stable(p9_out))
    else $error("p9 not held");
  AST_HOLD8: assert property (md_r inside {3'h2, 3'h3, 3'h4} |=> $stable(p8_oe))
    else $error("p8 not held");
endmodule
bind iop89_top iop89_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hrdata, .p8_in, .p8_oe, .p9_out, .p9_oe, .capture_in_d);
`default_nettype wire

// [sim/test_io_ports_eight_nine.sv]
`timescale 1ns/1ps
`default_nettype none
module test_io_ports_eight_nine;
  logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, ca = 1'b0, cb = 1'b0, ckx, hreadyout;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [3:0] cp;
  logic [7:0] p8_in, p8_out, p8_oe, rd, dv;
  logic [4:0] p9_in, p9_out, p9_oe;
  logic [7:0] b8 = 8'h5a;
  logic [4:0] b9 = 5'h15;
  int n_errors = 0, checked = 0;
  iop89_top uut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .p8_in, .p8_out, .p8_oe, .p9_in,
    .p9_out, .p9_oe, .compare_out_a(ca), .compare_out_b(cb), .capture_in_a(cp[0]),
    .capture_in_b(cp[1]), .capture_in_c(cp[2]), .capture_in_d(cp[3]), .timer_ext_clock_in(ckx));
  iop89_board brd (.p8_out, .p8_oe, .p9_out, .p9_oe, .b8, .b9, .p8_in, .p9_in);
  initial
  begin
    forever #25 hclk = ~hclk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Ready is taken at the rising edge; a stuck bus counts as a mismatch
  task automatic hw;
    @(posedge hclk);
    for (int i = 0; hreadyout !== 1'b1 && i <= 50; i++)
      @(posedge hclk);
    if (hreadyout !== 1'b1)
      chk(8'h00, 8'h01, "hang");
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic w = 1'b1);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {16'h0000, a};
    hw();
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    hw();
    rd = hrdata[7:0];
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e, input string m);
    wr(a, 8'h00, 1'b0);
    chk(rd, e, m);
  endtask
  task automatic st;
    repeat (3) @(posedge hclk);
  endtask
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(16'hffe8, 8'hff, "p8 dir");
    rdc(16'hffec, 8'hff, "p9 dir");
    rdc(16'hffd8, 8'h5a, "p8 pins");
    rdc(16'hffdc, 8'hd5, "p9 pins");
    chk(p8_oe | {3'h0, p9_oe}, 8'h00, "oe off");
    wr(16'hffec, 8'h1f);
    rdc(16'hffdc, 8'hc0, "p9 reset");
    wr(16'hffdc, 8'hff);
    rdc(16'hffdc, 8'hdf, "p9 fixed");
    wr(16'hffdc, 8'h0a);
    wr(16'hffec, 8'h0a);
    rdc(16'hffdc, 8'hdf, "p9 mixed");
    st();
    chk({3'h0, p9_oe}, 8'h0a, "p9 oe");
    chk({3'h0, p9_out}, 8'h0a, "p9 out");
    rdc(16'hfffc, 8'h00, "unmapped");
    $display("port9 done");
    wr(16'hffd8, 8'ha5);
    wr(16'hffe8, 8'h0f);
    rdc(16'hffd8, 8'h55, "p8 mixed");
    st();
    chk(p8_oe, 8'h0f, "p8 oe");
    chk({3'h0, cp, ckx}, 8'h15, "capture in");
    wr(16'hffe8, 8'hff);
    st();
    chk({3'h0, cp, ckx}, 8'h09, "capture out");
    wr(16'hffe8, 8'h00);
    ca <= 1'b1;
    wr(16'hfff4, 8'h03);
    st();
    chk(p8_oe, 8'h06, "cmp oe");
    chk(p8_out & 8'h06, 8'h02, "cmp a");
    ca <= 1'b0;
    cb <= 1'b1;
    st();
    chk(p8_out & 8'h06, 8'h04, "cmp b");
    wr(16'hfff4, 8'h00);
    st();
    chk(p8_oe, 8'h00, "cmp off");
    $display("port8 done");
    wr(16'hffe8, 8'h0f);
    dv = 8'h0a;
    for (int m = 1; m < 5; m++)
    begin
      wr(16'hfff0, 8'(m));
      wr(16'hffdc, dv ^ 8'h1f);
      st();
      chk({3'h0, p9_out}, (m == 1) ? dv ^ 8'h1f : dv, "mode hold");
      wr(16'hfff0, 8'h00);
      st();
      dv = dv ^ 8'h1f;
      chk({3'h0, p9_out}, dv, "wake");
    end
    wr(16'hfff0, 8'h05);
    st();
    chk(p8_oe | {3'h0, p9_oe}, 8'h00, "standby");
    wr(16'hfff0, 8'h00);
    st();
    chk(p8_oe | {3'h0, p9_oe}, 8'h0f, "resume");
    $display("modes done");
    results();
  end
endmodule
`default_nettype wire

// [verilog/iop89_pin_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface iop89_pin_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic [W-1:0] dir;
  logic [W-1:0] pin_in;
  logic [W-1:0] read_val;
  modport ctrl (output data, output dir, output pin_in, input read_val);
  modport port (input data, input dir, input pin_in, output read_val);
endinterface
`default_nettype wire

// [verilog/iop89_pkg.sv]
package iop89_pkg;
  // Byte addresses of each register word
  localparam logic [15:0] P8_DATA_ADDR = 16'hffd8;
  localparam logic [15:0] P9_DATA_ADDR = 16'hffdc;
  localparam logic [15:0] P8_DIR_ADDR = 16'hffe8;
  localparam logic [15:0] P9_DIR_ADDR = 16'hffec;
  localparam logic [15:0] MODE_ADDR = 16'hfff0;
  localparam logic [15:0] TOC_ADDR = 16'hfff4;
  localparam logic [15:0] P8_STAT_ADDR = 16'hfff8;
  localparam logic [7:0] P8_DATA_RST = 8'h00;
  localparam logic [7:0] P8_DIR_RST = 8'h00;
  localparam logic [7:0] P9_DATA_RST = 8'hc0;
  localparam logic [7:0] P9_DIR_RST = 8'hc0;
  localparam logic [7:0] DIR_READ_VAL = 8'hff;
  localparam logic [7:0] P9_FIXED_ONES = 8'hc0;
  localparam logic [7:0] P9_FIXED_MASK = 8'he0;
  localparam int P9_WIDTH = 5;
  localparam int CMP_A_BIT = 1;
  localparam int CMP_B_BIT = 2;
  localparam int CAP_LO_BIT = 3;
  localparam int CAP_D_BIT = 6;
  localparam int CLK_IN_BIT = 0;
  localparam int TOC_A_BIT = 0;
  localparam int TOC_B_BIT = 1;
  typedef enum logic [2:0]
  {
    IOP89_ACTIVE,
    IOP89_SUBACTIVE,
    IOP89_SLEEP,
    IOP89_SUBSLEEP,
    IOP89_WATCH,
    IOP89_STANDBY
  } iop89_mode_t;
endpackage

// [verilog/iop89_port_read.sv]
`timescale 1ns/1ps
`default_nettype none
module iop89_port_read #(
  parameter int W = 8
)(
  iop89_pin_if.port pi
);
  // Output bits show the latch, input bits the live level
  assign pi.read_val = (pi.dir & pi.data) | (~pi.dir & pi.pin_in);
endmodule
`default_nettype wire

// [verilog/iop89_top.sv]
// What this block does
// RQ1: Port8 direction bit 1 output; reads ones
// RQ2: Port8 read: latch if output, else pin
// RQ3: Pins 6..3 always feed capture inputs
// RQ4: Pin 6 feeds capture d always
// RQ5: Compare a enable overrides pin 1 direction
// RQ6: Compare b enable overrides pin 2 direction
// RQ7: Port8 hi-z reset/standby, hold in sleeps
// RQ8: Port9 five pins, bits 4..0
// RQ9: Port9 data bits 7,6 one; 5 zero
// RQ10: Port9 read: latch if output, else pin
// RQ11: Port9 data resets to c0
// RQ12: Port9 direction bit 1 output
// RQ13: Port9 direction write-only, reset c0, reads ones
// RQ14: Port9 hi-z reset/standby, hold in sleeps
// RQ15: Drivers enabled only in working/holding modes
`timescale 1ns/1ps
`default_nettype none
module iop89_top #(
  parameter int P8_WIDTH = 8,
  parameter int P9_WIDTH = 5
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [P8_WIDTH-1:0] p8_in,
  output logic [P8_WIDTH-1:0] p8_out,
  output logic [P8_WIDTH-1:0] p8_oe,
  input wire logic [P9_WIDTH-1:0] p9_in,
  output logic [P9_WIDTH-1:0] p9_out,
  output logic [P9_WIDTH-1:0] p9_oe,
  input wire logic compare_out_a,
  input wire logic compare_out_b,
  output logic capture_in_a,
  output logic capture_in_b,
  output logic capture_in_c,
  output logic capture_in_d,
  output logic timer_ext_clock_in
);
  logic [7:0] port8_pin_data_r;
  logic [7:0] port8_direction_r;
  logic [7:0] port9_pin_data_r;
  logic [7:0] port9_direction_r;
  logic [1:0] timer_output_control_r;
  iop89_pkg::iop89_mode_t mode_r;
  logic wr_pend_r;
  logic [15:0] addr_r;
  logic [7:0] rdata_nxt;
  logic [7:0] p8_out_nxt;
  logic [7:0] p8_oe_nxt;
  logic [4:0] p9_oe_nxt;
  logic run;
  logic hold;
  logic take;

  iop89_pin_if #(.W(8)) p8if ();
  iop89_pin_if #(.W(5)) p9if ();

  assign p8if.data = port8_pin_data_r;
  assign p8if.dir = port8_direction_r;
  assign p8if.pin_in = p8_in;
  assign p9if.data = port9_pin_data_r[4:0];
  assign p9if.dir = port9_direction_r[4:0];
  assign p9if.pin_in = p9_in;

  // Port8 read mux
  // RQ2: latch or pin
  iop89_port_read #(.W(8)) u_p8_read (.pi(p8if));
  // Port9 read mux
  // RQ10: latch or pin
  iop89_port_read #(.W(5)) u_p9_read (.pi(p9if));

  assign take = hsel && hready && htrans[1];

  // RQ15: mode gating
  assign run = (mode_r == iop89_pkg::IOP89_ACTIVE) || (mode_r == iop89_pkg::IOP89_SUBACTIVE);
  assign hold = (mode_r == iop89_pkg::IOP89_SLEEP) || (mode_r == iop89_pkg::IOP89_SUBSLEEP)
    || (mode_r == iop89_pkg::IOP89_WATCH);

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      addr_r <= 16'h0000;
    end
    else
    begin
      wr_pend_r <= take && hwrite;
      if (take)
      begin
        addr_r <= haddr[15:0];
      end
    end
  end

  // Port8 registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port8_pin_data_r <= iop89_pkg::P8_DATA_RST;
      port8_direction_r <= iop89_pkg::P8_DIR_RST;
    end
    else if (wr_pend_r)
    begin
      if (addr_r == iop89_pkg::P8_DATA_ADDR)
      begin
        port8_pin_data_r <= hwdata[7:0];
      end
      // RQ1: direction store
      if (addr_r == iop89_pkg::P8_DIR_ADDR)
      begin
        port8_direction_r <= hwdata[7:0];
      end
    end
  end

  // Port9 registers, only bits 4..0 are real
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // RQ11: data reset
      port9_pin_data_r <= iop89_pkg::P9_DATA_RST;
      // RQ13: direction reset
      port9_direction_r <= iop89_pkg::P9_DIR_RST;
    end
    else if (wr_pend_r)
    begin
      // RQ8: bits 4..0 only
      // RQ9: fixed upper bits
      if (addr_r == iop89_pkg::P9_DATA_ADDR)
      begin
        port9_pin_data_r <= (hwdata[7:0] & ~iop89_pkg::P9_FIXED_MASK) | iop89_pkg::P9_FIXED_ONES;
      end
      // RQ12: direction store
      if (addr_r == iop89_pkg::P9_DIR_ADDR)
      begin
        port9_direction_r <= (hwdata[7:0] & ~iop89_pkg::P9_FIXED_MASK) | iop89_pkg::P9_FIXED_ONES;
      end
    end
  end

  // Mode and timer output control
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_r <= iop89_pkg::IOP89_ACTIVE;
      timer_output_control_r <= 2'b00;
    end
    else if (wr_pend_r)
    begin
      if (addr_r == iop89_pkg::MODE_ADDR)
      begin
        case (hwdata[2:0])
          3'h0: mode_r <= iop89_pkg::IOP89_ACTIVE;
          3'h1: mode_r <= iop89_pkg::IOP89_SUBACTIVE;
          3'h2: mode_r <= iop89_pkg::IOP89_SLEEP;
          3'h3: mode_r <= iop89_pkg::IOP89_SUBSLEEP;
          3'h4: mode_r <= iop89_pkg::IOP89_WATCH;
          3'h5: mode_r <= iop89_pkg::IOP89_STANDBY;
          default: mode_r <= mode_r;
        endcase
      end
      if (addr_r == iop89_pkg::TOC_ADDR)
      begin
        timer_output_control_r <= hwdata[1:0];
      end
    end
  end

  // Read data; unmapped reads as zero
  always_comb
  begin
    rdata_nxt = 8'h00;
    case (addr_r)
      iop89_pkg::P8_DATA_ADDR: rdata_nxt = p8if.read_val;
      // RQ1: reads ones
      iop89_pkg::P8_DIR_ADDR: rdata_nxt = iop89_pkg::DIR_READ_VAL;
      // RQ9: fixed upper bits
      iop89_pkg::P9_DATA_ADDR: rdata_nxt = iop89_pkg::P9_FIXED_ONES | {3'b000, p9if.read_val};
      // RQ13: reads ones
      iop89_pkg::P9_DIR_ADDR: rdata_nxt = iop89_pkg::DIR_READ_VAL;
      iop89_pkg::MODE_ADDR: rdata_nxt = {5'b00000, mode_r};
      iop89_pkg::TOC_ADDR: rdata_nxt = {6'b000000, timer_output_control_r};
      iop89_pkg::P8_STAT_ADDR: rdata_nxt = p8_oe;
      default: rdata_nxt = 8'h00;
    endcase
  end

  assign hrdata = {24'h000000, rdata_nxt};
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Pin drive values
  always_comb
  begin
    p8_out_nxt = port8_pin_data_r;
    p8_oe_nxt = port8_direction_r;
    // RQ5: compare a override
    if (timer_output_control_r[iop89_pkg::TOC_A_BIT])
    begin
      p8_out_nxt[iop89_pkg::CMP_A_BIT] = compare_out_a;
      p8_oe_nxt[iop89_pkg::CMP_A_BIT] = 1'b1;
    end
    // RQ6: compare b override
    if (timer_output_control_r[iop89_pkg::TOC_B_BIT])
    begin
      p8_out_nxt[iop89_pkg::CMP_B_BIT] = compare_out_b;
      p8_oe_nxt[iop89_pkg::CMP_B_BIT] = 1'b1;
    end
    p9_oe_nxt = port9_direction_r[4:0];
  end

  // Pin outputs: frozen while holding, released in standby
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // RQ7: hi-z reset
      p8_out <= 8'h00;
      p8_oe <= 8'h00;
      // RQ14: hi-z reset
      p9_out <= 5'h00;
      p9_oe <= 5'h00;
    end
    else if (run)
    begin
      p8_out <= p8_out_nxt;
      p8_oe <= p8_oe_nxt;
      p9_out <= port9_pin_data_r[4:0];
      p9_oe <= p9_oe_nxt;
    end
    // RQ7: standby release
    // RQ14: standby release
    else if (!hold)
    begin
      p8_oe <= 8'h00;
      p9_oe <= 5'h00;
    end
  end

  // Capture feeds; registered so outputs come from flops, one cycle late
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      capture_in_a <= 1'b0;
      capture_in_b <= 1'b0;
      capture_in_c <= 1'b0;
      capture_in_d <= 1'b0;
      timer_ext_clock_in <= 1'b0;
    end
    else
    begin
      // RQ3: capture feeds
      capture_in_a <= p8_in[iop89_pkg::CAP_LO_BIT];
      capture_in_b <= p8_in[iop89_pkg::CAP_LO_BIT + 1];
      capture_in_c <= p8_in[iop89_pkg::CAP_LO_BIT + 2];
      // RQ4: pin 6 feed
      capture_in_d <= p8_in[iop89_pkg::CAP_D_BIT];
      timer_ext_clock_in <= p8_in[iop89_pkg::CLK_IN_BIT];
    end
  end
endmodule
`default_nettype wire
